// ===== hdl/bcl_pkg.sv
// bcl_pkg: constants for the board control latch and address map block.
// assumes one 50 MHz clock domain and an 8-bit, 16-address-bit cpu bus.
package bcl_pkg;

  // ************************************************************
  // io port map (default decode)
  // ************************************************************
  localparam logic [7:0] BCL_PORT_CTRL_LATCH = 8'hE0;
  localparam logic [7:0] BCL_PORT_SER_DATA   = 8'hEC;
  localparam logic [7:0] BCL_PORT_SER_STAT   = 8'hED;
  localparam logic [7:0] BCL_PORT_TMR_DATA   = 8'hD8;
  localparam logic [7:0] BCL_PORT_TMR_STAT   = 8'hD9;
  localparam logic [7:0] BCL_PORT_APU_DATA   = 8'hC0;
  localparam logic [7:0] BCL_PORT_APU_STAT   = 8'hC1;
  localparam logic [7:0] BCL_PORT_PIC_DATA   = 8'hC2;
  localparam logic [7:0] BCL_PORT_PIC_STAT   = 8'hC3;
  localparam logic [7:0] BCL_PORT_PIO0_BASE  = 8'hE4;
  localparam logic [7:0] BCL_PORT_PIO1_BASE  = 8'hE8;

  // ************************************************************
  // io decoder chip select codes (lookup bits 2:0)
  // ************************************************************
  localparam logic [2:0] BCL_CS_TIMER = 3'h0;
  localparam logic [2:0] BCL_CS_PIC   = 3'h1;
  localparam logic [2:0] BCL_CS_APU   = 3'h2;
  localparam logic [2:0] BCL_CS_LATCH = 3'h3;
  localparam logic [2:0] BCL_CS_PIO0  = 3'h4;
  localparam logic [2:0] BCL_CS_PIO1  = 3'h5;
  localparam logic [2:0] BCL_CS_SER   = 3'h6;
  localparam logic [2:0] BCL_CS_NONE  = 3'h7;
  localparam int         BCL_IO_ONB_BIT = 3;

  // ************************************************************
  // control latch fields
  // ************************************************************
  localparam logic [7:0] BCL_LATCH_RESET = 8'h00;
  localparam int         BCL_BOOT_BIT    = 0;
  localparam int         BCL_TIRQ_LSB    = 3;
  localparam int         BCL_TIRQ_NUM    = 4;

  // ************************************************************
  // memory map entry codes and block layout
  // ************************************************************
  localparam int         BCL_BLK_LSB      = 10;
  localparam logic [3:0] BCL_MAP_RAM0     = 4'h4;
  localparam logic [3:0] BCL_MAP_ROM0     = 4'h8;
  localparam logic [3:0] BCL_MAP_ROM3     = 4'hB;
  localparam logic [3:0] BCL_MAP_OFFBOARD = 4'hF;
  localparam logic [5:0] BCL_ROM_LAST_BLK = 6'h0F;
  localparam logic [5:0] BCL_RAM_FIRST_BLK = 6'h10;
  localparam logic [5:0] BCL_RAM_LAST_BLK = 6'h13;

  // ************************************************************
  // input synchroniser
  // ************************************************************
  localparam int         BCL_SYNC_STAGES = 3;

endpackage : bcl_pkg

// ===== hdl/bcl_map_lookup.sv
// bcl_map_lookup: memory map lookup table, 256 entries of 4 bits.
// assumes address is formed by the caller; contents are the default map.
`timescale 1ns/1ns
module bcl_map_lookup
  import bcl_pkg::*;
(
  input  wire logic [7:0] addr_i,   // boot, strap, bus address 15:10
  output logic      [3:0] entry_o   // selected memory device code
);

  // ************************************************************
  // default contents
  // ************************************************************
  // boot low and strap in: 4 x 4k rom at 0-3fff, ram at 4000-4fff;
  // boot high: everything off board so a bootstrap can be overlaid
  logic [3:0] table_c [256];

  genvar g;
  generate
    for (g = 0; g < 256; g++) begin : g_ent
      localparam logic [5:0] BLK = 6'(g);
      localparam logic [1:0] SEL = 2'(g >> 6);
      if (SEL == 2'h0 && BLK <= BCL_ROM_LAST_BLK) begin : g_rom
        assign table_c[g] = BCL_MAP_ROM0 + 4'(BLK >> 2);
      end else if (SEL == 2'h0 && BLK >= BCL_RAM_FIRST_BLK
                   && BLK <= BCL_RAM_LAST_BLK) begin : g_ram
        assign table_c[g] = BCL_MAP_RAM0 + 4'(BLK - BCL_RAM_FIRST_BLK);
      end else begin : g_off
        assign table_c[g] = BCL_MAP_OFFBOARD;
      end
    end
  endgenerate

  assign entry_o = table_c[addr_i];

endmodule // bcl_map_lookup

// ===== hdl/bcl_board_ctrl.sv
// bcl_board_ctrl: io select decode, control latch, timer irq holds, memory map.
// assumes cpu command strobes are active low and come from this clock domain;
// timer sources and the strap come from pins and are synchronised here.
`timescale 1ns/1ns

// Notes on behaviour
// - io lookup addressed by bus address 15:1, plus bit 0 for latch port E0
// - lookup bits 2:0 feed 3-to-8 decoder
// - lookup bit 3: 1 on-board, 0 off-board; every entry here sets it to 1
// - write to port E0 loads latch
// - latch cleared at reset
// - boot bit is map address bit 7
// - latch bit 3 arms timeout irq hold
// - latch bits 4-6 arm selectable timer holds
// - hold stays set until latch clears
// - write 0 clears, then 1 rearms
// - map address: a15:10, boot, strap
// - one map entry per 1k block
// - four maps via boot and strap
// - boot high sends all off-board
// - boot and strap low: rom 0-3fff, ram 4000-4fff
// - four ram pairs, four rom sockets
// - serial: data low port, status high
// - timer: data low port, status high
// - apu: stack low port, status high
// - map entry F routes off-board
module bcl_board_ctrl
  import bcl_pkg::*;
#(
  parameter int TMR_OUTS = 6                        // timer outputs selectable
)(
  input  wire logic                ref_clk_i,       // 50 MHz clock
  input  wire logic                rst_n_i,         // async reset, active low
  input  wire logic [15:0]         addr_i,          // cpu bus address
  input  wire logic [7:0]          data_i,          // cpu write data
  input  wire logic                io_rd_n_i,       // io read command
  input  wire logic                io_wr_n_i,       // io write command
  input  wire logic                mem_rd_n_i,      // memory read command
  input  wire logic                mem_wr_n_i,      // memory write command
  input  wire logic                strap_i,         // map strap, 1 = out
  input  wire logic                timeout_i,       // timeout event pin
  input  wire logic [TMR_OUTS-1:0] tmr_out_i,       // timer output pins
  input  wire logic [5:0]          tirq_sel_1_i,    // one-hot source, hold 1
  input  wire logic [5:0]          tirq_sel_2_i,    // one-hot source, hold 2
  input  wire logic [5:0]          tirq_sel_3_i,    // one-hot source, hold 3
  output logic [7:0]               io_cs_n_o,       // decoded io chip selects
  output logic                     io_onboard_o,    // always 1, also for pages other than zero
  output logic                     port_hi_o,       // 1 = status/command port
  output logic                     io_rd_o,         // qualified io read
  output logic                     io_wr_o,         // qualified io write
  output logic                     boot_o,          // boot bit
  output logic [3:0]               tirq_o,          // timer irq holds
  output logic [3:0]               mem_sel_o,       // map entry for access
  output logic [3:0]               ram_pair_cs_o,   // ram pair selects
  output logic [3:0]               rom_cs_o,        // rom socket selects
  output logic                     offboard_o       // access goes off board
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int SYN_W = TMR_OUTS + 2;
  logic [SYN_W-1:0] syn1_r;
  logic [SYN_W-1:0] syn2_r;
  logic [SYN_W-1:0] syn3_r;
  logic [SYN_W-1:0] syn_q_r;
  wire  [SYN_W-1:0] syn_in = {strap_i, timeout_i, tmr_out_i};

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      syn1_r <= '0;
      syn2_r <= '0;
      syn3_r <= '0;
    end else begin
      syn1_r <= syn_in;
      syn2_r <= syn1_r;
      syn3_r <= syn2_r;
    end
  end

  // a change only counts once stages two and three agree
  genvar s;
  generate
    for (s = 0; s < SYN_W; s++) begin : g_syn
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          syn_q_r[s] <= 1'b0;
        end else if (syn2_r[s] == syn3_r[s]) begin
          syn_q_r[s] <= syn3_r[s];
        end
      end
    end
  endgenerate

  wire [TMR_OUTS-1:0] tmr_q   = syn_q_r[TMR_OUTS-1:0];
  wire                tout_q  = syn_q_r[TMR_OUTS];
  wire                strap_q = syn_q_r[TMR_OUTS+1];

  // ************************************************************
  // io select lookup and decoder
  // ************************************************************
  wire [7:0] io_page = addr_i[15:8];
  wire [7:0] io_port = addr_i[7:0];
  wire       io_rd   = !io_rd_n_i;
  wire       io_wr   = !io_wr_n_i;
  wire       io_cmd  = io_rd ^ io_wr;

  logic [3:0] io_lut;
  // only page zero holds on-board io; any other page gets no select but is still flagged on-board
  always_comb begin
    io_lut = {1'b1, BCL_CS_NONE};
    if (io_page == 8'h00) begin
      case (io_port[7:1])
        BCL_PORT_TMR_DATA[7:1]:   io_lut = {1'b1, BCL_CS_TIMER};
        BCL_PORT_PIC_DATA[7:1]:   io_lut = {1'b1, BCL_CS_PIC};
        BCL_PORT_APU_DATA[7:1]:   io_lut = {1'b1, BCL_CS_APU};
        BCL_PORT_CTRL_LATCH[7:1]: io_lut = {1'b1, (io_port[0] ? BCL_CS_NONE
                                                               : BCL_CS_LATCH)};
        BCL_PORT_PIO0_BASE[7:1],
        BCL_PORT_PIO0_BASE[7:1] + 7'h01: io_lut = {1'b1, BCL_CS_PIO0};
        BCL_PORT_PIO1_BASE[7:1],
        BCL_PORT_PIO1_BASE[7:1] + 7'h01: io_lut = {1'b1, BCL_CS_PIO1};
        BCL_PORT_SER_DATA[7:1]:   io_lut = {1'b1, BCL_CS_SER};
        default:                  io_lut = {1'b1, BCL_CS_NONE};
      endcase
    end
  end

  wire [2:0] dec_sel = io_lut[2:0];
  wire       lut_onb = io_lut[BCL_IO_ONB_BIT];

  logic [7:0] cs_n_nxt;
  genvar c;
  generate
    for (c = 0; c < 8; c++) begin : g_cs
      assign cs_n_nxt[c] = !(io_cmd && dec_sel == 3'(c)
                              && dec_sel != BCL_CS_NONE);
    end
  endgenerate

  assign io_cs_n_o    = cs_n_nxt;
  assign io_onboard_o = lut_onb;
  assign port_hi_o    = io_port[0];
  assign io_rd_o      = io_rd && !io_wr;
  assign io_wr_o      = io_wr && !io_rd;

  // ************************************************************
  // control latch
  // ************************************************************
  logic [7:0] latch_r;
  logic       io_wr_d_r;
  // load once on the leading edge of the write so a long strobe counts once
  wire latch_ld = io_wr_o && !io_wr_d_r && dec_sel == BCL_CS_LATCH;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_r   <= BCL_LATCH_RESET;
      io_wr_d_r <= 1'b0;
    end else begin
      io_wr_d_r <= io_wr_o;
      if (latch_ld) begin
        latch_r <= data_i;
      end
    end
  end

  assign boot_o = latch_r[BCL_BOOT_BIT];

  // ************************************************************
  // timer interrupt holds
  // ************************************************************
  wire [3:0] arm = latch_r[BCL_TIRQ_LSB +: BCL_TIRQ_NUM];
  wire [3:0] src;
  assign src[0] = tout_q;
  assign src[1] = |(tirq_sel_1_i[TMR_OUTS-1:0] & tmr_q);
  assign src[2] = |(tirq_sel_2_i[TMR_OUTS-1:0] & tmr_q);
  assign src[3] = |(tirq_sel_3_i[TMR_OUTS-1:0] & tmr_q);

  logic [3:0] src_d_r;
  logic [3:0] tirq_r;
  logic [3:0] tirq_nxt;
  // an armed hold catches a rising source edge; a 0 arm bit holds it clear
  genvar t;
  generate
    for (t = 0; t < BCL_TIRQ_NUM; t++) begin : g_tirq
      assign tirq_nxt[t] = arm[t] && (tirq_r[t] || (src[t] && !src_d_r[t]));
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_d_r <= '0;
      tirq_r  <= '0;
    end else begin
      src_d_r <= src;
      tirq_r  <= tirq_nxt;
    end
  end

  assign tirq_o = tirq_r;

  // ************************************************************
  // memory map
  // ************************************************************
  // boot bit is lookup address bit 7, the strap bit 6
  wire [7:0] map_addr = {latch_r[BCL_BOOT_BIT], strap_q,
                         addr_i[15:BCL_BLK_LSB]};
  wire [3:0] map_entry;

  bcl_map_lookup u_map (
    .addr_i  (map_addr),
    .entry_o (map_entry)
  );

  wire mem_cmd = !mem_rd_n_i || !mem_wr_n_i;
  wire is_ram  = map_entry >= BCL_MAP_RAM0 && map_entry < BCL_MAP_ROM0;
  wire is_rom  = map_entry >= BCL_MAP_ROM0 && map_entry <= BCL_MAP_ROM3;
  wire [1:0] dev_idx = map_entry[1:0];

  genvar m;
  generate
    for (m = 0; m < 4; m++) begin : g_mem
      assign ram_pair_cs_o[m] = mem_cmd && is_ram && dev_idx == 2'(m);
      assign rom_cs_o[m]      = mem_cmd && is_rom && dev_idx == 2'(m);
    end
  endgenerate

  // illegal codes are treated as off board so no chip fights the bus
  assign offboard_o = mem_cmd && (map_entry == BCL_MAP_OFFBOARD
                                  || !(is_ram || is_rom));
  assign mem_sel_o  = map_entry;

endmodule // bcl_board_ctrl

// ===== tb/bcl_board_ctrl_sva.sv
// bcl_board_ctrl_sva: port checker for bcl_board_ctrl.
// assumes the bind at the foot; one clock, async active-low reset.
`timescale 1ns/1ns
module bcl_board_ctrl_sva
  import bcl_pkg::*;
(
  input wire logic        ref_clk_i,     // clock
  input wire logic        rst_n_i,       // reset
  input wire logic [7:0]  data_i,        // write data
  input wire logic        io_rd_n_i,     // io read
  input wire logic        io_wr_n_i,     // io write
  input wire logic        mem_rd_n_i,    // mem read
  input wire logic        mem_wr_n_i,    // mem write
  input wire logic [7:0]  io_cs_n_o,     // io selects
  input wire logic        io_wr_o,       // qualified write
  input wire logic        boot_o,        // boot bit
  input wire logic [3:0]  tirq_o,        // irq holds
  input wire logic [3:0]  mem_sel_o,     // map entry
  input wire logic [3:0]  ram_pair_cs_o, // ram selects
  input wire logic [3:0]  rom_cs_o,      // rom selects
  input wire logic        offboard_o     // off board
);
  logic lw_q_r;
  wire  lw   = io_wr_o && !io_cs_n_o[BCL_CS_LATCH];
  wire  lead = lw && !lw_q_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lw_q_r <= 1'b0;
    else          lw_q_r <= lw;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ************************************************************
  // sequences
  // ************************************************************
  sequence latch_wr_s; lead; endsequence
  // latch lands one edge after the write, holds one edge later
  sequence hold_clr_s; ##2 ((tirq_o & ~$past(data_i[6:3], 2)) == 4'h0); endsequence
  cs_io_only_a: assert property (io_cs_n_o != 8'hFF |-> (!io_rd_n_i || !io_wr_n_i))
    else $error("io select outside io command");
  cs_none_a: assert property (io_cs_n_o[BCL_CS_NONE])
    else $error("unused select asserted");
  latch_load_a: assert property (latch_wr_s |=> boot_o == $past(data_i[BCL_BOOT_BIT]))
    else $error("boot bit not loaded");
  hold_clr_a: assert property (latch_wr_s |-> hold_clr_s)
    else $error("disarmed hold not cleared");
  hold_keep_a: assert property (!lead && !$past(lead) |=>
    (tirq_o & $past(tirq_o)) == $past(tirq_o)) else $error("hold dropped");
  boot_map_a: assert property (boot_o |-> mem_sel_o == BCL_MAP_OFFBOARD)
    else $error("boot map not off board");
  off_sel_a: assert property (!mem_rd_n_i && mem_sel_o == BCL_MAP_OFFBOARD |->
    offboard_o && (rom_cs_o | ram_pair_cs_o) == 4'h0) else $error("entry F not off board");
  ram_sel_a: assert property (!mem_rd_n_i && mem_sel_o[3:2] == 2'b01 |->
    ram_pair_cs_o == 4'h1 << mem_sel_o[1:0] && !offboard_o) else $error("ram pair wrong");
  rom_sel_a: assert property (!mem_rd_n_i && mem_sel_o[3:2] == 2'b10 |->
    rom_cs_o == 4'h1 << mem_sel_o[1:0] && !offboard_o) else $error("rom socket wrong");
  mem_idle_a: assert property (mem_rd_n_i && mem_wr_n_i |->
    (rom_cs_o | ram_pair_cs_o) == 4'h0 && !offboard_o) else $error("mem select while idle");
endmodule // bcl_board_ctrl_sva
bind bcl_board_ctrl bcl_board_ctrl_sva u_sva (.ref_clk_i, .rst_n_i, .data_i, .io_rd_n_i,
  .io_wr_n_i, .mem_rd_n_i, .mem_wr_n_i, .io_cs_n_o, .io_wr_o, .boot_o, .tirq_o,
  .mem_sel_o, .ram_pair_cs_o, .rom_cs_o, .offboard_o);

// ===== tb/bcl_cpu_model.sv
// bcl_cpu_model: cpu side, issues one io or memory cycle at a time.
// assumes a free-running ref_clk_i; cycles last one edge.
`timescale 1ns/1ns
module bcl_cpu_model (
  input  wire logic   ref_clk_i, // bus clock
  output logic [15:0] addr_o,    // bus address
  output logic [7:0]  data_o,    // write data
  output logic [3:0]  cmd_n_o    // io rd, io wr, mem rd, mem wr
);
  initial begin
    addr_o  = 16'hFFFF;
    data_o  = 8'hFF;
    cmd_n_o = 4'hF;
  end
  task automatic start(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    addr_o  = a;
    data_o  = d;
    cmd_n_o = c;
    @(posedge ref_clk_i);
    #1;
  endtask
  // released lines turn to garbage, never keep the old value
  task automatic stop();
    cmd_n_o = 4'hF;
    addr_o  = ~addr_o;
    data_o  = ~data_o;
  endtask
endmodule // bcl_cpu_model

// ===== tb/board_control_latch_and_address_map_bench.sv
// bench for bcl_board_ctrl: io decode, control latch, irq holds, map.
// assumes the cpu model drives the bus and the bench drives pins.
`timescale 1ns/1ns
module board_control_latch_and_address_map_bench;
  import bcl_pkg::*;
  localparam logic [3:0] IORD = 4'b0111, IOWR = 4'b1011, MRD = 4'b1101, MWR = 4'b1110;
  logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, strap_i = 1'b0, timeout_i = 1'b0;
  logic [5:0]  tmr_out_i = 6'h00;
  logic [15:0] addr;
  logic [7:0]  data, io_cs_n_o;
  logic [3:0]  cmd_n, tirq_o, mem_sel_o, ram_pair_cs_o, rom_cs_o;
  logic        io_onboard_o, port_hi_o, io_rd_o, io_wr_o, boot_o, offboard_o;
  int          bad_count = 0, checks = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  bcl_cpu_model cpu (.ref_clk_i, .addr_o(addr), .data_o(data), .cmd_n_o(cmd_n));
  bcl_board_ctrl DUT (.ref_clk_i, .rst_n_i, .addr_i(addr), .data_i(data),
    .io_rd_n_i(cmd_n[3]), .io_wr_n_i(cmd_n[2]), .mem_rd_n_i(cmd_n[1]),
    .mem_wr_n_i(cmd_n[0]), .strap_i, .timeout_i, .tmr_out_i, .tirq_sel_1_i(6'h01),
    .tirq_sel_2_i(6'h02), .tirq_sel_3_i(6'h20), .io_cs_n_o, .io_onboard_o, .port_hi_o,
    .io_rd_o, .io_wr_o, .boot_o, .tirq_o, .mem_sel_o, .ram_pair_cs_o, .rom_cs_o,
    .offboard_o);
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] d);
    cpu.start(IOWR, {8'h00, BCL_PORT_CTRL_LATCH}, d);
    chk({io_cs_n_o, io_wr_o, io_rd_o}, {~(8'h01 << BCL_CS_LATCH), 2'b10});
    cpu.stop();
    tick(3);
  endtask
  // sources high long enough for the pin synchroniser
  task automatic pulse(input logic to, input logic [5:0] t);
    timeout_i = to;
    tmr_out_i = t;
    tick(3);
    timeout_i = 1'b0;
    tmr_out_i = 6'h00;
    tick(8);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    wr(8'hFF);
    chk(boot_o, 1'b1);
    rst_n_i = 1'b0;
    tick(2);
    chk({tirq_o, boot_o}, 5'h00);
    rst_n_i = 1'b1;
    tick(2);
    $display("t_reset ended");
  endtask
  task automatic t_io_decode();
    logic [7:0] b [6] = '{BCL_PORT_TMR_DATA, BCL_PORT_APU_DATA, BCL_PORT_PIC_DATA,
                          BCL_PORT_PIO0_BASE, BCL_PORT_PIO1_BASE, BCL_PORT_SER_DATA};
    logic [2:0] c [6] = '{BCL_CS_TIMER, BCL_CS_APU, BCL_CS_PIC, BCL_CS_PIO0,
                          BCL_CS_PIO1, BCL_CS_SER};
    logic [7:0] a;
    for (int i = 0; i < 12; i++) begin
      a = b[i/2] + 8'((i % 2) * ((i / 2 == 3 || i / 2 == 4) ? 3 : 1));
      cpu.start(IORD, {8'h00, a}, 8'h00);
      chk({io_cs_n_o, port_hi_o, io_onboard_o, io_rd_o, io_wr_o},
          {~(8'h01 << c[i/2]), a[0], 3'b110});
      cpu.stop();
    end
    cpu.start(IORD, 16'h01D8, 8'h00);
    chk(io_cs_n_o, 8'hFF);
    cpu.stop();
    cpu.start(MRD, 16'h00D8, 8'h00);
    chk(io_cs_n_o, 8'hFF);
    cpu.stop();
    // both io strobes low is refused: no select, no strobe, no load
    cpu.start(4'h3, 16'h00E0, 8'hFF);
    chk({io_cs_n_o, io_rd_o, io_wr_o}, {8'hFF, 2'b00});
    cpu.stop();
    cpu.start(IOWR, 16'h00E1, 8'hFF);
    chk(io_cs_n_o, 8'hFF);
    cpu.stop();
    tick(2);
    chk(boot_o, 1'b0);
    $display("t_io_decode ended");
  endtask
  task automatic t_map(input logic off);
    logic [3:0] e, r, m;
    for (int b = 0; b < 64; b++) begin
      e = off ? BCL_MAP_OFFBOARD : (b < 16) ? BCL_MAP_ROM0 + b[5:2]
        : (b < 20) ? BCL_MAP_RAM0 + b[1:0] : BCL_MAP_OFFBOARD;
      r = (e[3:2] == 2'b01) ? 4'h1 << e[1:0] : 4'h0;
      m = (e[3:2] == 2'b10) ? 4'h1 << e[1:0] : 4'h0;
      cpu.start(MRD, {b[5:0], {10{b[0]}}}, 8'h00);
      chk({offboard_o, ram_pair_cs_o, rom_cs_o, mem_sel_o}, {e == BCL_MAP_OFFBOARD, r, m, e});
      cpu.stop();
    end
  endtask
  task automatic t_maps();
    cpu.start(MWR, 16'h4400, 8'hA5);
    chk({offboard_o, ram_pair_cs_o, rom_cs_o}, 9'h020);
    cpu.stop();
    t_map(1'b0);
    wr(8'h01);
    t_map(1'b1);
    wr(8'h00);
    strap_i = 1'b1;
    tick(8);
    t_map(1'b1);
    strap_i = 1'b0;
    tick(8);
    $display("t_maps ended");
  endtask
  task automatic t_timer();
    wr(8'h78);
    pulse(1'b1, 6'h23);
    chk(tirq_o, 4'hF);
    tick(20);
    chk(tirq_o, 4'hF);
    wr(8'h70);
    chk(tirq_o, 4'hE);
    pulse(1'b1, 6'h00);
    chk(tirq_o, 4'hE);
    wr(8'h78);
    chk(tirq_o, 4'hE);
    pulse(1'b1, 6'h00);
    chk(tirq_o, 4'hF);
    wr(8'h09);
    chk({tirq_o, boot_o}, 5'h03);
    wr(8'h10);
    pulse(1'b1, 6'h22);
    chk(tirq_o, 4'h0);
    pulse(1'b1, 6'h01);
    chk(tirq_o, 4'h2);
    $display("t_timer ended");
  endtask
  initial begin
    tick(16);
    rst_n_i = 1'b1;
    tick(2);
    t_reset();
    t_io_decode();
    t_maps();
    t_timer();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    bad_count++;
    end_of_test();
  end
endmodule // board_control_latch_and_address_map_bench
